// *** core/ahg_defs.svh ***
`ifndef AHG_DEFS_SVH
`define AHG_DEFS_SVH

// Result and bus widths
`define AHG_RES_W        12
`define AHG_BYTE_W       8
// Byte read windows, in ns
`define AHG_BYTE_RD_NS   80
`define AHG_CLK_NS       25
`define AHG_BYTE_RD_CYC  ((`AHG_BYTE_RD_NS + `AHG_CLK_NS - 1) / `AHG_CLK_NS)
// Least spacing between start pulses, in ns
`define AHG_START_NS     5000
`define AHG_START_CYC    ((`AHG_START_NS + `AHG_CLK_NS - 1) / `AHG_CLK_NS)
// Start strobe low width in cycles
`define AHG_SC_LOW_CYC   2
// Low and high byte field positions in a 12-bit result
`define AHG_LO_MSB       7
`define AHG_HI_MSB       11
`define AHG_HI_LSB       8
// FIFO defaults
`define AHG_FIFO_DEPTH   8

`endif

// *** core/ahg_pkg.sv ***
package ahg_pkg;
  `include "ahg_defs.svh"

  typedef enum logic [1:0] {
    AHG_MODE_IO,
    AHG_MODE_DMA,
    AHG_MODE_BYTE,
    AHG_MODE_HBE
  } ahg_mode_t;

  typedef struct packed {
    logic                     oe_n;
    logic                     byte_select_flag;
    logic                     high_byte_enable_n;
  } ahg_rd_t;

  typedef struct packed {
    logic [`AHG_RES_W-1:0]    data;
    logic                     done;
  } ahg_word_t;
endpackage : ahg_pkg

// *** core/ahg_fifo.sv ***
`timescale 1ns/1ps
module ahg_fifo #(
  parameter int W = 13,
  parameter int D = 8
) (
  input  wire logic         clk_sys_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [W-1:0]  mem_d [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          wr, rd;
  logic          vld_q, vld_d, rdy_q, rdy_d;
  logic [W-1:0]  dout_q, dout_d;

  always_comb begin
    wr = in_valid_i && (cnt_q != (AW+1)'(D));
    rd = out_ready_i && (cnt_q != '0);
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    if (wr) begin
      mem_d[wp_q] = in_data_i;
      wp_d = (wp_q == AW'(D-1)) ? '0 : wp_q + AW'(1);
    end
    if (rd) begin
      rp_d = (rp_q == AW'(D-1)) ? '0 : rp_q + AW'(1);
    end
    cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
    // Outputs registered from the next state
    vld_d  = (cnt_d != '0);
    rdy_d  = (cnt_d != (AW+1)'(D));
    dout_d = mem_d[rp_d];
  end

  always_ff @(posedge clk_sys_i) begin
    mem_q  <= mem_d;
    dout_q <= dout_d;
    if (reset_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      vld_q <= 1'b0;
      rdy_q <= 1'b1;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      vld_q <= vld_d;
      rdy_q <= rdy_d;
    end
  end

  assign in_ready_o  = rdy_q;
  assign out_valid_o = vld_q;
  assign out_data_o  = dout_q;
endmodule : ahg_fifo

// *** core/ahg_host.sv ***
`timescale 1ns/1ps
`include "ahg_defs.svh"
// Operation
// - Port write in I/O mode pulses the converter start strobe
// - Port read in I/O mode returns done status and result
// - I/O reads get exactly one wait state before ready
// - In DMA mode conversion done is latched as channel one request
// - The DMA read of the result clears the latched request
// - A conversion ending while a DMA request is pending sets overrun
// - Byte select low for high byte read, then high for low byte
// - Decode drives output enable; first byte read returns upper byte
// - Each byte read is stretched by one wait state, two cycles
// - Latch variant drives memory acknowledge to force one wait cycle
// - Conversion done in HBE mode sets high byte enable; released after the upper read
// - Start pulses spaced at least 5 us, strobe never held low
module ahg_host
  import ahg_pkg::*;
#(
  parameter int RES_W      = `AHG_RES_W,
  parameter int FIFO_DEPTH = `AHG_FIFO_DEPTH
) (
  input  wire logic              clk_sys_i,
  input  wire logic              reset_i,
  input  wire ahg_mode_t         mode_i,
  input  wire logic              port_wr_i,
  input  wire logic              port_rd_i,
  input  wire logic              trig_i,
  output logic                   io_ready_o,
  output logic [RES_W:0]         io_rdata_o,
  input  wire logic              conv_done_i,
  input  wire logic [RES_W-1:0]  conv_data_i,
  output logic                   start_convert_strobe_n_o,
  output logic                   output_enable_n_o,
  output logic                   byte_select_flag_o,
  output logic                   high_byte_enable_n_o,
  output logic                   full_width_o,
  output logic                   transfer_request_one_o,
  output logic                   memory_acknowledge_o,
  output logic [RES_W:0]         res_data_o,
  output logic                   res_valid_o,
  input  wire logic              res_ready_i,
  output logic                   overrun_o
);
  typedef enum logic [2:0] {
    S_IDLE, S_IO_WAIT, S_IO_DONE, S_HI, S_LO, S_DMA
  } ahg_st_t;

  localparam int SC_W = $clog2(`AHG_START_CYC + 1);

  ahg_st_t          st_q, st_d;
  logic [SC_W-1:0]  gap_q, gap_d;
  logic [1:0]       sclo_q, sclo_d;
  logic             sc_n_q, sc_n_d, full_q, full_d;
  logic             ws_q, ws_d;
  logic             done_q, done_d;
  logic             req_q, req_d;
  logic             oe_d, oe_n_q, oe_n_d, bsf_q, bsf_d, ack_q, ack_d;
  logic             hbe_d, hbe_n_q, hbe_n_d;
  logic             rdy_q, rdy_d, ovr_q, ovr_d;
  logic [RES_W:0]   iod_q, iod_d;
  logic [7:0]       hi_q, hi_d;
  logic             push;
  logic [RES_W:0]   push_data;
  logic             in_ready;
  logic             start_req;
  logic             done_rise;

  always_comb begin
    done_rise = conv_done_i && !done_q;
    start_req = ((mode_i == AHG_MODE_IO) && port_wr_i) ||
                ((mode_i != AHG_MODE_IO) && trig_i);
    gap_d  = (gap_q != '0) ? gap_q - SC_W'(1) : gap_q;
    sclo_d = (sclo_q != '0) ? sclo_q - 2'd1 : sclo_q;
    if (start_req && gap_q == '0 && sclo_q == '0) begin
      gap_d  = SC_W'(`AHG_START_CYC);
      sclo_d = 2'(`AHG_SC_LOW_CYC);
    end
    sc_n_d = (sclo_d == '0);
    full_d = (mode_i == AHG_MODE_IO) || (mode_i == AHG_MODE_DMA);
  end

  // Done is taken as already seen after reset, a held level is no edge
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      gap_q  <= '0;
      sclo_q <= '0;
      sc_n_q <= 1'b1;
      full_q <= 1'b0;
      done_q <= 1'b1;
    end else begin
      gap_q  <= gap_d;
      sclo_q <= sclo_d;
      sc_n_q <= sc_n_d;
      full_q <= full_d;
      done_q <= conv_done_i;
    end
  end

  always_comb begin
    st_d = st_q;
    ws_d = 1'b0;
    oe_d = 1'b0;
    bsf_d = bsf_q;
    hbe_d = !hbe_n_q;
    ack_d = 1'b0;
    rdy_d = 1'b0;
    iod_d = iod_q;
    hi_d = hi_q;
    req_d = req_q;
    ovr_d = ovr_q;
    push = 1'b0;
    push_data = '0;
    if (done_rise && mode_i == AHG_MODE_DMA) begin
      if (req_q) ovr_d = 1'b1;
      req_d = 1'b1;
    end
    if (done_rise && (st_q == S_HI || st_q == S_LO)) ovr_d = 1'b1;
    unique case (st_q)
      S_IDLE: begin
        if (mode_i == AHG_MODE_IO && port_rd_i) begin
          st_d = S_IO_WAIT;
          oe_d = 1'b1;
        end else if (mode_i == AHG_MODE_DMA && req_q && in_ready) begin
          st_d = S_DMA;
          oe_d = 1'b1;
        end else if ((mode_i == AHG_MODE_BYTE || mode_i == AHG_MODE_HBE)
                     && done_rise && in_ready) begin
          st_d = S_HI;
          bsf_d = 1'b0;
          hbe_d = (mode_i == AHG_MODE_HBE);
          oe_d = 1'b1;
        end
      end
      S_IO_WAIT: begin
        oe_d = 1'b1;
        rdy_d = 1'b1;
        iod_d = {conv_done_i, conv_data_i};
        st_d = S_IO_DONE;
      end
      S_IO_DONE: st_d = S_IDLE;
      S_DMA: begin
        push = 1'b1;
        push_data = {1'b1, conv_data_i};
        if (!(done_rise)) req_d = 1'b0;
        st_d = S_IDLE;
      end
      S_HI: begin
        oe_d = 1'b1;
        ws_d = ~ws_q;
        ack_d = ws_q && mode_i == AHG_MODE_HBE;
        if (ws_q) begin
          hi_d = conv_data_i[7:0];
          hbe_d = 1'b0;
          bsf_d = 1'b1;
          st_d = S_LO;
        end
      end
      S_LO: begin
        oe_d = 1'b1;
        ws_d = ~ws_q;
        ack_d = ws_q && mode_i == AHG_MODE_HBE;
        if (ws_q) begin
          push = 1'b1;
          push_data = {1'b1, hi_q[3:0], conv_data_i[7:0]};
          oe_d = 1'b0;
          st_d = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
    oe_n_d  = !oe_d;
    hbe_n_d = !hbe_d;
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st_q  <= S_IDLE;
      ws_q  <= 1'b0;
      oe_n_q  <= 1'b1;
      bsf_q   <= 1'b1;
      hbe_n_q <= 1'b1;
      ack_q <= 1'b0;
      rdy_q <= 1'b0;
      iod_q <= '0;
      hi_q  <= '0;
      req_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      ws_q  <= ws_d;
      oe_n_q  <= oe_n_d;
      bsf_q   <= bsf_d;
      hbe_n_q <= hbe_n_d;
      ack_q <= ack_d;
      rdy_q <= rdy_d;
      iod_q <= iod_d;
      hi_q  <= hi_d;
      req_q <= req_d;
      ovr_q <= ovr_d;
    end
  end

  ahg_fifo #(.W(RES_W + 1), .D(FIFO_DEPTH)) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .in_data_i   (push_data),
    .in_valid_i  (push),
    .in_ready_o  (in_ready),
    .out_data_o  (res_data_o),
    .out_valid_o (res_valid_o),
    .out_ready_i (res_ready_i)
  );

  assign start_convert_strobe_n_o = sc_n_q;
  assign output_enable_n_o        = oe_n_q;
  assign byte_select_flag_o       = bsf_q;
  assign high_byte_enable_n_o     = hbe_n_q;
  assign full_width_o             = full_q;
  assign transfer_request_one_o   = req_q;
  assign memory_acknowledge_o     = ack_q;
  assign io_ready_o               = rdy_q;
  assign io_rdata_o               = iod_q;
  assign overrun_o                = ovr_q;

  sequence hi_read_s;
    (st_q == S_HI && !ws_q) ##1 (st_q == S_HI && ws_q);
  endsequence

  io_wait_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (st_q == S_IDLE && mode_i == AHG_MODE_IO && port_rd_i)
      |-> !io_ready_o ##1 !io_ready_o ##1 io_ready_o)
    else $error("io ready not after one wait");
  start_gap_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $fell(start_convert_strobe_n_o) |-> gap_q == SC_W'(`AHG_START_CYC))
    else $error("start spacing counter wrong");
  sc_low_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !start_convert_strobe_n_o [*2] |=> start_convert_strobe_n_o)
    else $error("start strobe held low");
  dma_req_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (mode_i == AHG_MODE_DMA && done_rise) |=> transfer_request_one_o)
    else $error("request not latched");
  dma_clr_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (st_q == S_DMA && !done_rise) |=> !transfer_request_one_o)
    else $error("request not cleared");
  byte_sel_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    hi_read_s |=> byte_select_flag_o && st_q == S_LO)
    else $error("byte select order wrong");
  byte_len_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (st_q == S_IDLE && st_d == S_HI) |=> !output_enable_n_o [*4])
    else $error("byte reads not two cycles each");
  hbe_rel_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    hi_read_s |=> high_byte_enable_n_o)
    else $error("high byte enable not released");
  ack_wait_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    memory_acknowledge_o |-> $past(st_q) != S_IDLE && $past(ws_q))
    else $error("acknowledge without wait");
  ovr_set_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (mode_i == AHG_MODE_DMA && done_rise && transfer_request_one_o)
      |=> overrun_o)
    else $error("overrun not flagged");
endmodule : ahg_host

// *** verification/ahg_conv_model.sv ***
`timescale 1ns/1ps
module ahg_conv_model #(
  parameter int CONV_CYC = 20
) (
  input  wire logic        clk_sys_i,
  input  wire logic        sc_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        bsf_i,
  input  wire logic        full_i,
  input  wire logic [11:0] sample_i,
  output logic             done_o,
  output logic [11:0]      data_o
);
  logic [11:0] res_q  = 12'h000;
  logic [11:0] last_q = 12'h000;
  logic        sc_q   = 1'b1;
  int          cnt_q  = 0;
  logic        done_q = 1'b0;
  assign done_o = done_q;
  // Start on the falling strobe, sampled on the host clock
  always @(posedge clk_sys_i) begin
    sc_q   <= sc_n_i;
    last_q <= data_o;
    if (sc_q && !sc_n_i) begin
      done_q <= 1'b0;
      res_q  <= sample_i;
      cnt_q  <= CONV_CYC;
    end else if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
      if (cnt_q == 1) done_q <= 1'b1;
    end
  end
  // Released bus shows the inverse of its last value
  always_comb begin
    if (oe_n_i) data_o = ~last_q;
    else if (full_i) data_o = res_q;
    else if (bsf_i) data_o = {4'h0, res_q[7:0]};
    else data_o = {8'h00, res_q[11:8]};
  end
endmodule : ahg_conv_model

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import ahg_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        reset_i   = 1'b1;
  ahg_mode_t   mode      = AHG_MODE_IO;
  logic        port_wr   = 1'b0;
  logic        port_rd   = 1'b0;
  logic        trig      = 1'b0;
  logic        res_ready = 1'b0;
  logic        stall     = 1'b0;
  logic [11:0] sample    = 12'h000;
  logic        io_ready, conv_done, sc_n, oe_n, bsf, hbe_n, full;
  logic        req, ack, res_valid, overrun, sc_p;
  logic [12:0] io_rdata, res_data;
  logic [11:0] conv_data;
  logic [12:0] expq[$];
  int          mismatches = 0;
  int          tests_run  = 0;
  int          starts     = 0;
  int          acks       = 0;
  int          exp_starts = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  ahg_host u_dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .mode_i(mode),
    .port_wr_i(port_wr), .port_rd_i(port_rd), .trig_i(trig),
    .io_ready_o(io_ready), .io_rdata_o(io_rdata),
    .conv_done_i(conv_done), .conv_data_i(conv_data),
    .start_convert_strobe_n_o(sc_n), .output_enable_n_o(oe_n),
    .byte_select_flag_o(bsf), .high_byte_enable_n_o(hbe_n),
    .full_width_o(full), .transfer_request_one_o(req),
    .memory_acknowledge_o(ack), .res_data_o(res_data),
    .res_valid_o(res_valid), .res_ready_i(res_ready),
    .overrun_o(overrun)
  );
  ahg_conv_model u_conv (
    .clk_sys_i(clk_sys_i), .sc_n_i(sc_n), .oe_n_i(oe_n), .bsf_i(bsf),
    .full_i(full), .sample_i(sample), .done_o(conv_done),
    .data_o(conv_data)
  );
  task automatic test_done();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  task automatic check(string name, logic [12:0] seen, logic [12:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic limit(int n, int lim);
    if (n >= lim) begin
      mismatches++;
      test_done();
    end
  endtask : limit
  always @(negedge clk_sys_i) res_ready <= stall ? 1'b0 : 1'($urandom);
  always @(posedge clk_sys_i) begin
    sc_p <= sc_n;
    if (!reset_i && sc_p && !sc_n) starts++;
    if (!reset_i && ack) acks++;
    if (!reset_i && res_valid && res_ready)
      check("fifo", res_data, expq.size() ? expq.pop_front() : 13'h1fff);
  end
  task automatic pulse(bit io);
    @(negedge clk_sys_i);
    if (io) port_wr = 1'b1;
    else trig = 1'b1;
    @(negedge clk_sys_i);
    port_wr = 1'b0;
    trig = 1'b0;
  endtask : pulse
  task automatic conv(ahg_mode_t m);
    int n;
    int a0;
    bit io;
    io = (m == AHG_MODE_IO);
    a0 = acks;
    mode = m;
    sample = 12'($urandom);
    if (!io) expq.push_back({1'b1, sample});
    pulse(io);
    pulse(io);
    exp_starts++;
    for (n = 0; n < 100 && conv_done !== 1'b1; n++) @(negedge clk_sys_i);
    limit(n, 100);
    if (io) begin
      pulse(1'b0);
      port_rd = 1'b1;
      @(negedge clk_sys_i);
      port_rd = 1'b0;
      for (n = 0; n < 9 && io_ready !== 1'b1; n++) @(negedge clk_sys_i);
      check("wait", 13'(n), 13'h1);
      check("io", io_rdata, {1'b1, sample});
    end
    for (n = 0; n < 400 && expq.size() && !stall; n++)
      @(negedge clk_sys_i);
    limit(n, 400);
    repeat (200) @(negedge clk_sys_i);
    check("start", 13'(starts), 13'(exp_starts));
    check("full", full, 13'(m <= AHG_MODE_DMA));
    check("ack", 13'(acks - a0), (m == AHG_MODE_HBE) ? 13'h2 : 13'h0);
    check("hbe", hbe_n, 13'h1);
    if (!stall) check("req", req, 13'h0);
  endtask : conv
  initial begin
    int n;
    void'($urandom(32'h2da9));
    repeat (3) @(negedge clk_sys_i);
    reset_i = 1'b0;
    for (int k = 0; k < 8; k++) conv(ahg_mode_t'(k % 4));
    stall = 1'b1;
    repeat (9) conv(AHG_MODE_DMA);
    check("req", req, 13'h1);
    check("valid", res_valid, 13'h1);
    stall = 1'b0;
    for (n = 0; n < 200 && expq.size(); n++) @(negedge clk_sys_i);
    limit(n, 200);
    repeat (5) @(negedge clk_sys_i);
    check("req", req, 13'h0);
    check("overrun", overrun, 13'h0);
    // Fill the FIFO and finish one more conversion on a pending request
    stall = 1'b1;
    repeat (10) conv(AHG_MODE_DMA);
    check("overrun", overrun, 13'h1);
    // Reset in mid-run while done still stands high
    reset_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    reset_i = 1'b0;
    expq.delete();
    repeat (5) @(negedge clk_sys_i);
    check("req", req, 13'h0);
    check("overrun", overrun, 13'h0);
    check("valid", res_valid, 13'h0);
    stall = 1'b0;
    conv(AHG_MODE_DMA);
    test_done();
  end
endmodule : tb_top
